//--- src/rspi_params.svh
// Constants for the radio serial slave port: control word layout, buffer map and timing.
`ifndef RSPI_PARAMS_SVH
`define RSPI_PARAMS_SVH

// ==========================================================================
// Control word layout
`define RSPI_CW_READ_BIT 7
`define RSPI_CW_BUF_BIT 6
`define RSPI_CW_ADDR_MSB 5
`define RSPI_IND_ESCAPE 6'h3F

// ==========================================================================
// Register window and packet buffer
`define RSPI_OSC_DIR_BASE 6'h30
`define RSPI_PBUF_DEPTH 128
`define RSPI_PBUF_AW 7
`define RSPI_TX_LEN_ADDR 7'h00
`define RSPI_RX_FIRST_ADDR 8'h00

// ==========================================================================
// Reset values and control word end count
`define RSPI_IRQ_RST 8'h00
`define RSPI_SEEN_RST 2'h2
`define RSPI_FALL_CTRL_END 4'h8

// ==========================================================================
// Timing
`define RSPI_MCLK_KHZ 200000
`define RSPI_SCLK_WR_MAX_KHZ 16000
`define RSPI_SCLK_RD_MAX_KHZ 9000
`define RSPI_RD_HALF_CYC (`RSPI_MCLK_KHZ / (2 * `RSPI_SCLK_RD_MAX_KHZ))

`endif

//--- src/rspi_pkg.sv
// Types shared by the radio serial slave port.
package rspi_pkg;

  // ========================================================================
  // Sequencer phases
  typedef enum logic [1:0] {PH_CTRL, PH_IND_ADDR, PH_BUF_ADDR, PH_DATA} rspi_phase_t;

  // ========================================================================
  // Carriers
  typedef struct packed {
    logic wr;
    logic rd;
    logic ind;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rspi_regbus_t;

  typedef struct packed {
    logic start;
    logic [7:0] len;
    logic byte_we;
    logic [7:0] data;
    logic lqi_we;
    logic [7:0] lqi;
  } rspi_rxin_t;

  // ========================================================================
  // Module state
  typedef struct packed {
    logic [2:0] cnt;
    logic [6:0] sh;
  } rspi_rise_t;

  typedef struct packed {
    logic [7:0] byte_v;
    logic tgl;
  } rspi_hand_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic [7:0] tx;
  } rspi_fall_t;

  typedef struct packed {
    rspi_phase_t ph;
    logic rd_mode;
    logic buf_mode;
    logic ind_mode;
    logic [7:0] addr;
    logic [7:0] rd_data;
    logic [7:0] irq_hold;
    rspi_regbus_t bus;
    logic rd_pend;
    logic underrun;
    logic [1:0] seen;
    logic rx_busy;
    logic [7:0] rx_ptr;
    logic [7:0] rx_len;
  } rspi_core_t;

endpackage

//--- src/rspi_sync.sv
// Two-stage synchroniser for levels and toggles entering the core clock domain.
`timescale 1ns/1ps
`default_nettype none

module rspi_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } rspi_sync_t;

  rspi_sync_t s_q;
  rspi_sync_t s_d;

  always_comb begin
    s_d.meta = d;
    s_d.stab = s_q.meta;
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= {RST_VAL, RST_VAL};
    end else begin
      s_q <= s_d;
    end
  end

  assign q = s_q.stab;

endmodule

`default_nettype wire

//--- src/rspi_slave.sv
// Radio serial slave port: host link, clock crossing, register access and packet buffer.
//
// Behaviour
// - Slave only; host drives select, clock and host data, never the radio.
// - Direct and indirect registers readable and writable, single byte or endless burst.
// - Packet buffer readable and writable one byte at a time or in bursts.
// - No phase or frequency relation assumed between serial clock and core clocks.
// - Writes cross into core domain, read data crosses back, all inside the port.
// - Port works in every power mode except reset.
// - In hibernate whole buffer and most registers stay reachable.
// - Every access opens with one control word; it carries direct addresses, indirect and buffer addresses follow in a second byte.
// - Highest-priority interrupt status shifts out during the control word.
// - Bursts advance register or buffer address after each data byte.
// - Whole buffer moves in one burst under one select assertion.
// - Four wires: select, serial clock, host data, radio data.
// - Buffer is 128 bytes; transmit length byte at address 0, frame after it.
// - Received length kept outside buffer; link quality byte follows last frame byte.
// - Guard bit stops received frames overwriting buffer; host loads still allowed.
// - Under-run error flagged for packet buffer reads.
`timescale 1ns/1ps
`default_nettype none
`include "rspi_params.svh"

module rspi_slave (
  // Core clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Serial link from the host
  input wire logic spi_sclk,
  input wire logic spi_ss_n,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe_n,
  // Core status and power
  input wire logic [7:0] primary_irq_status,
  input wire logic hibernate,
  input wire logic buffer_rx_guard,
  // Register file access
  output var rspi_pkg::rspi_regbus_t reg_bus,
  input wire logic [7:0] reg_rdata,
  // Receive path into the packet buffer
  input wire rspi_pkg::rspi_rxin_t rx_in,
  output logic [7:0] rx_frame_len,
  output logic pbuf_underrun
);

  // ========================================================================
  // Helpers

  // Oscillator-side registers lose their clock in hibernate, so they are fenced.
  function automatic logic rspi_osc_blocked(input logic hib, input logic ind,
                                            input logic [7:0] a);
    return hib && !ind && (a[5:0] >= `RSPI_OSC_DIR_BASE);
  endfunction

  function automatic logic [7:0] rspi_next(input logic bufm, input logic [7:0] a);
    logic [6:0] b;
    b = a[6:0] + 7'h01;
    return bufm ? {1'b0, b} : a + 8'h01;
  endfunction

  // ========================================================================
  // Link domain: select is the frame reset of every serial-clock flop except the byte handshake.

  logic link_rst;
  assign link_rst = ~reset_n | spi_ss_n;

  rspi_pkg::rspi_rise_t rise_q;
  rspi_pkg::rspi_rise_t rise_d;
  rspi_pkg::rspi_hand_t hand_q;
  rspi_pkg::rspi_hand_t hand_d;
  rspi_pkg::rspi_fall_t fall_q;
  rspi_pkg::rspi_fall_t fall_d;
  rspi_pkg::rspi_core_t core_q;
  rspi_pkg::rspi_core_t core_d;

  always_comb begin
    rise_d.cnt = rise_q.cnt + 3'h1;
    rise_d.sh = {rise_q.sh[5:0], spi_mosi};
  end

  always_ff @(posedge spi_sclk or posedge link_rst) begin
    if (link_rst) begin
      rise_q <= '0;
    end else begin
      rise_q <= rise_d;
    end
  end

  // The toggle must survive select, otherwise a frame end would fake a byte.
  always_comb begin
    hand_d = hand_q;
    if (rise_q.cnt == 3'h7) begin
      hand_d.byte_v = {rise_q.sh, spi_mosi};
      hand_d.tgl = ~hand_q.tgl;
    end
  end

  always_ff @(posedge spi_sclk or negedge reset_n) begin
    if (!reset_n) begin
      hand_q <= '0;
    end else begin
      hand_q <= hand_d;
    end
  end

  // Read data is fetched within a few core cycles of the byte toggle and
  // is only loaded half a serial period later; the read clock limit keeps
  // that half period above the fetch time, which is why reads run slower.
  always_comb begin
    fall_d = fall_q;
    if (fall_q.cnt != `RSPI_FALL_CTRL_END) begin
      fall_d.cnt = fall_q.cnt + 4'h1;
    end
    if (rise_q.cnt == 3'h0) begin
      fall_d.tx = core_q.rd_data;
    end else begin
      fall_d.tx = {fall_q.tx[6:0], 1'b0};
    end
  end

  always_ff @(negedge spi_sclk or posedge link_rst) begin
    if (link_rst) begin
      fall_q <= '0;
    end else begin
      fall_q <= fall_d;
    end
  end

  // The status snapshot is frozen while select is low, so it is stable here.
  assign spi_miso = fall_q.cnt[3] ? fall_q.tx[7]
                  : core_q.irq_hold[3'h7 - fall_q.cnt[2:0]];
  assign spi_miso_oe_n = spi_ss_n;

  // ========================================================================
  // Crossing into the core domain

  logic [1:0] sync_q;

  rspi_sync #(
    .W(2),
    .RST_VAL(`RSPI_SEEN_RST)
  ) u_sync (
    .clk(mclk),
    .rst_n(reset_n),
    .d({spi_ss_n, hand_q.tgl}),
    .q(sync_q)
  );

  // ========================================================================
  // Packet buffer

  logic [7:0] pbuf_mem [`RSPI_PBUF_DEPTH];
  logic mem_we;
  logic [`RSPI_PBUF_AW-1:0] mem_wa;
  logic [7:0] mem_wd;

  always_ff @(posedge mclk) begin
    if (mem_we) begin
      pbuf_mem[mem_wa] <= mem_wd;
    end
  end

  // ========================================================================
  // Core sequencer

  always_comb begin
    logic byte_ev;
    logic [7:0] b;
    logic fetch;
    logic wr_go;
    logic [7:0] fa;
    logic spi_mem_we;
    byte_ev = 1'b0;
    b = hand_q.byte_v;
    fetch = 1'b0;
    wr_go = 1'b0;
    fa = core_q.addr;
    spi_mem_we = 1'b0;
    mem_we = 1'b0;
    mem_wa = '0;
    mem_wd = '0;
    core_d = core_q;
    core_d.bus.wr = 1'b0;
    core_d.bus.rd = 1'b0;
    core_d.rd_pend = 1'b0;
    core_d.underrun = 1'b0;
    core_d.seen = sync_q;
    byte_ev = sync_q[0] != core_q.seen[0];

    if (core_q.rd_pend) begin
      core_d.rd_data = reg_rdata;
    end

    if (byte_ev) begin
      case (core_q.ph)
        rspi_pkg::PH_CTRL: begin
          core_d.rd_mode = b[`RSPI_CW_READ_BIT];
          core_d.buf_mode = b[`RSPI_CW_BUF_BIT];
          core_d.ind_mode = 1'b0;
          core_d.addr = {2'b00, b[`RSPI_CW_ADDR_MSB:0]};
          if (b[`RSPI_CW_BUF_BIT]) begin
            core_d.ph = rspi_pkg::PH_BUF_ADDR;
          end else if (b[`RSPI_CW_ADDR_MSB:0] == `RSPI_IND_ESCAPE) begin
            core_d.ph = rspi_pkg::PH_IND_ADDR;
          end else begin
            core_d.ph = rspi_pkg::PH_DATA;
            fetch = b[`RSPI_CW_READ_BIT];
            fa = core_d.addr;
          end
        end
        rspi_pkg::PH_IND_ADDR: begin
          core_d.ind_mode = 1'b1;
          core_d.addr = b;
          core_d.ph = rspi_pkg::PH_DATA;
          fetch = core_q.rd_mode;
          fa = b;
        end
        rspi_pkg::PH_BUF_ADDR: begin
          core_d.addr = {1'b0, b[`RSPI_PBUF_AW-1:0]};
          core_d.ph = rspi_pkg::PH_DATA;
          fetch = core_q.rd_mode;
          fa = core_d.addr;
        end
        rspi_pkg::PH_DATA: begin
          core_d.addr = rspi_next(core_q.buf_mode, core_q.addr);
          if (core_q.rd_mode) begin
            fetch = 1'b1;
            fa = core_d.addr;
          end else begin
            wr_go = 1'b1;
            fa = core_q.addr;
          end
        end
        default: begin
          core_d.ph = rspi_pkg::PH_CTRL;
        end
      endcase
    end

    if (fetch) begin
      if (core_d.buf_mode) begin
        core_d.rd_data = pbuf_mem[fa[`RSPI_PBUF_AW-1:0]];
        if (core_q.rx_busy && (fa[`RSPI_PBUF_AW-1:0] >= core_q.rx_ptr[`RSPI_PBUF_AW-1:0])) begin
          core_d.underrun = 1'b1;
        end
      end else if (rspi_osc_blocked(hibernate, core_d.ind_mode, fa)) begin
        core_d.rd_data = 8'h00;
      end else begin
        core_d.bus.rd = 1'b1;
        core_d.bus.ind = core_d.ind_mode;
        core_d.bus.addr = fa;
        core_d.rd_pend = 1'b1;
      end
    end

    if (wr_go) begin
      if (core_q.buf_mode) begin
        spi_mem_we = 1'b1;
        mem_we = 1'b1;
        mem_wa = fa[`RSPI_PBUF_AW-1:0];
        mem_wd = b;
      end else if (!rspi_osc_blocked(hibernate, core_q.ind_mode, fa)) begin
        core_d.bus.wr = 1'b1;
        core_d.bus.ind = core_q.ind_mode;
        core_d.bus.addr = fa;
        core_d.bus.wdata = b;
      end
    end

    // Receive path; a host write in the same cycle takes the port, which
    // costs at most one received byte in a case the host can avoid.
    if (rx_in.start) begin
      core_d.rx_busy = 1'b1;
      core_d.rx_ptr = `RSPI_RX_FIRST_ADDR;
      core_d.rx_len = rx_in.len;
    end else if (core_q.rx_busy && (rx_in.byte_we || rx_in.lqi_we)) begin
      if (!buffer_rx_guard && !spi_mem_we) begin
        mem_we = 1'b1;
        mem_wa = core_q.rx_ptr[`RSPI_PBUF_AW-1:0];
        mem_wd = rx_in.byte_we ? rx_in.data : rx_in.lqi;
      end
      if (rx_in.byte_we) begin
        core_d.rx_ptr = core_q.rx_ptr + 8'h01;
      end else begin
        core_d.rx_busy = 1'b0;
      end
    end

    // Select high ends any burst and lets the status snapshot follow the core.
    if (sync_q[1]) begin
      core_d.ph = rspi_pkg::PH_CTRL;
      core_d.irq_hold = primary_irq_status;
    end
  end

  // Only reset_n clears the core side, so the port runs in every power mode.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      core_q <= '0;
      core_q.seen <= `RSPI_SEEN_RST;
      core_q.irq_hold <= `RSPI_IRQ_RST;
    end else begin
      core_q <= core_d;
    end
  end

  // ========================================================================
  // Outputs

  assign reg_bus = core_q.bus;
  assign rx_frame_len = core_q.rx_len;
  assign pbuf_underrun = core_q.underrun;

endmodule

`default_nettype wire

//--- testbench/rspi_slave_asserts.sv
// Concurrent checks on the ports of the radio serial slave port.
`timescale 1ns/1ps
`default_nettype none

module rspi_slave_asserts (
  // Core clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Observed ports
  input wire logic spi_ss_n,
  input wire logic spi_miso_oe_n,
  input wire logic hibernate,
  input wire rspi_pkg::rspi_regbus_t reg_bus,
  input wire rspi_pkg::rspi_rxin_t rx_in,
  input wire logic [7:0] rx_frame_len,
  input wire logic pbuf_underrun
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  // =====
  // Receive activity
  logic rx_act_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) rx_act_q <= 1'b0;
    else if (rx_in.start) rx_act_q <= 1'b1;
    else if (rx_in.lqi_we) rx_act_q <= 1'b0;
  end

  // =====
  // Properties
  sequence s_one(logic s);
    s ##1 !s;
  endsequence
  property p_oe; spi_miso_oe_n == spi_ss_n; endproperty
  a_oe: assert property (p_oe) else $error("miso enable differs from select");
  property p_wr; reg_bus.wr |-> s_one(reg_bus.wr); endproperty
  a_wr: assert property (p_wr) else $error("write strobe too long");
  property p_rd; reg_bus.rd |-> s_one(reg_bus.rd); endproperty
  a_rd: assert property (p_rd) else $error("read strobe too long");
  property p_excl; !(reg_bus.wr && reg_bus.rd); endproperty
  a_excl: assert property (p_excl) else $error("read and write together");
  property p_hold; !reg_bus.wr && !reg_bus.rd |-> $stable(reg_bus.addr); endproperty
  a_hold: assert property (p_hold) else $error("address moved without strobe");
  property p_hib;
    hibernate && reg_bus.wr && !reg_bus.ind |-> !(reg_bus.addr inside {[8'h30:8'h3e]});
  endproperty
  a_hib: assert property (p_hib) else $error("fenced write in hibernate");
  property p_ur;
    pbuf_underrun |-> (rx_act_q || $past(rx_act_q)) ##1 !pbuf_underrun;
  endproperty
  a_ur: assert property (p_ur) else $error("bad underrun pulse");
  property p_len; rx_in.start |=> rx_frame_len == $past(rx_in.len); endproperty
  a_len: assert property (p_len) else $error("frame length not captured");
  property p_lhold; !rx_in.start |=> $stable(rx_frame_len); endproperty
  a_lhold: assert property (p_lhold) else $error("frame length moved");
endmodule

bind rspi_slave rspi_slave_asserts chk_u (.mclk(mclk), .reset_n(reset_n),
  .spi_ss_n(spi_ss_n), .spi_miso_oe_n(spi_miso_oe_n), .hibernate(hibernate),
  .reg_bus(reg_bus), .rx_in(rx_in), .rx_frame_len(rx_frame_len),
  .pbuf_underrun(pbuf_underrun));

`default_nettype wire

//--- testbench/rspi_host_model.sv
// Host serial master model that drives the radio port link.
`timescale 1ns/1ps
`default_nettype none

module rspi_host_model (
  // Link driven by the host only
  output logic spi_sclk,
  output logic spi_ss_n,
  output logic spi_mosi,
  // Link driven by the radio
  input wire logic spi_miso
);
  // Half period in ns; reads must slow to 56 because the fetch needs time.
  int half = 32;

  // Select rises once at start so that the link flops see a clean reset edge.
  initial begin
    spi_sclk = 1'b0;
    spi_ss_n = 1'b0;
    spi_mosi = 1'b0;
    #1 spi_ss_n = 1'b1;
  end

  task sel();
    #7;
    spi_ss_n = 1'b0;
    #half;
  endtask

  task xfer(input logic [7:0] t, output logic [7:0] r);
    for (int i = 7; i >= 0; i--) begin
      spi_mosi = t[i];
      #half;
      spi_sclk = 1'b1;
      r[i] = spi_miso;
      #half;
      spi_sclk = 1'b0;
    end
  endtask

  // The clock stands still and the data line is flipped once released.
  task desel();
    #half;
    spi_ss_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #40;
  endtask
endmodule

`default_nettype wire

//--- testbench/testbench.sv
// Self-checking bench for the radio serial slave port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_total++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (e)); end end

module testbench;
  logic mclk, reset_n, hibernate, buffer_rx_guard, pbuf_underrun;
  logic spi_sclk, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe_n;
  logic [7:0] irq, reg_rdata, rx_frame_len, r, a, d;
  rspi_pkg::rspi_regbus_t reg_bus;
  rspi_pkg::rspi_rxin_t rx_in;
  logic [31:0] seed = 32'h0000_001e;
  logic [7:0] tq[$], rq[$], pb[128];
  logic [16:0] wq[$];
  int err_total = 0, checked = 0, ur = 0, rp = 0;

  rspi_slave dut_u (.mclk(mclk), .reset_n(reset_n), .spi_sclk(spi_sclk),
    .spi_ss_n(spi_ss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
    .spi_miso_oe_n(spi_miso_oe_n), .primary_irq_status(irq), .hibernate(hibernate),
    .buffer_rx_guard(buffer_rx_guard), .reg_bus(reg_bus), .reg_rdata(reg_rdata),
    .rx_in(rx_in), .rx_frame_len(rx_frame_len), .pbuf_underrun(pbuf_underrun));
  rspi_host_model host_u (.spi_sclk(spi_sclk), .spi_ss_n(spi_ss_n),
    .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  // =====
  // Register file model and monitor
  assign reg_rdata = reg_bus.addr ^ 8'h5a;
  always @(posedge mclk) begin
    if (reg_bus.wr === 1'b1) wq.push_back({reg_bus.ind, reg_bus.addr, reg_bus.wdata});
    if (pbuf_underrun === 1'b1) ur++;
  end

  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction

  task print_verdict();
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // =====
  // Transfers
  task run();
    @(posedge mclk);
    #1 irq = rnd();
    repeat (6) @(posedge mclk);
    rq = {};
    host_u.sel();
    foreach (tq[i]) begin
      host_u.xfer(tq[i], r);
      rq.push_back(r);
    end
    host_u.desel();
    repeat (8) @(posedge mclk);
    `CHK(rq[0], irq)
  endtask

  task wchk(input logic ind, input logic [7:0] a0, input int n);
    logic [16:0] w;
    `CHK(wq.size(), n)
    for (int k = 0; k < n; k++) begin
      w = wq.pop_front();
      `CHK(w, {ind, a0 + 8'(k), tq[tq.size() - n + k]})
    end
  endtask

  // Kind 0 starts a frame, 1 delivers a byte, 2 delivers link quality.
  task rxe(input int k, input logic [7:0] v);
    @(posedge mclk);
    #1;
    if (k == 0) {rx_in.start, rx_in.len, rp} = {1'b1, v, 32'd0};
    if (k == 1) {rx_in.byte_we, rx_in.data} = {1'b1, v};
    if (k == 2) {rx_in.lqi_we, rx_in.lqi} = {1'b1, v};
    if (k > 0 && !buffer_rx_guard) pb[rp] = v;
    if (k == 1) rp++;
    @(posedge mclk);
    #1 rx_in = '0;
  endtask

  task rdbuf(input int n);
    host_u.half = 56;
    tq = {8'hc0, 8'h00};
    repeat (n) tq.push_back(8'h00);
    run();
    for (int k = 0; k < n; k++) `CHK(rq[k + 2], pb[k])
    host_u.half = 32;
  endtask

  // The full buffer read at the slow read clock is the longest test, near 120 us.
  initial begin
    #400us;
    err_total++;
    print_verdict();
  end

  // Reset falls after time zero so that every asynchronous reset sees its edge.
  initial begin
    reset_n = 1'b1;
    hibernate = 1'b0;
    buffer_rx_guard = 1'b0;
    irq = 8'h00;
    rx_in = '0;
    #1 reset_n = 1'b0;
    repeat (3) @(posedge mclk);
    `CHK(reg_bus, 19'h0_0000)
    `CHK(spi_miso_oe_n, 1'b1)
    #1 reset_n = 1'b1;
    repeat (4) @(posedge mclk);
    $display("test reset done");
    a = rnd() & 8'h1f;
    tq = {a, rnd(), rnd(), rnd()};
    run();
    wchk(1'b0, a, 3);
    host_u.half = 56;
    tq = {8'h80 | a, 8'h00, 8'h00, 8'h00};
    run();
    for (int k = 0; k < 3; k++) `CHK(rq[k + 1], (a + 8'(k)) ^ 8'h5a)
    d = rnd();
    tq = {8'hbf, d, 8'h00};
    run();
    `CHK(rq[2], d ^ 8'h5a)
    host_u.half = 32;
    tq = {8'h3f, d, rnd()};
    run();
    wchk(1'b1, d, 1);
    $display("test registers done");
    @(posedge mclk);
    #1 hibernate = 1'b1;
    tq = {8'h31, 8'ha5};
    run();
    `CHK(wq.size(), 0)
    host_u.half = 56;
    tq = {8'hb1, 8'h00};
    run();
    `CHK(rq[1], 8'h00)
    host_u.half = 32;
    tq = {8'h40, 8'h00};
    for (int k = 0; k < 128; k++) begin
      d = rnd();
      tq.push_back(d);
      pb[k] = d;
    end
    run();
    tq = {8'h40, 8'h7f, rnd(), rnd()};
    pb[127] = tq[2];
    pb[0] = tq[3];
    run();
    @(posedge mclk);
    #1 hibernate = 1'b0;
    rdbuf(128);
    `CHK(ur, 0)
    $display("test buffer done");
    rxe(0, 8'h03);
    repeat (3) rxe(1, rnd());
    rxe(2, rnd());
    `CHK(rx_frame_len, 8'h03)
    buffer_rx_guard = 1'b1;
    rxe(0, 8'h02);
    repeat (2) rxe(1, rnd());
    rxe(2, rnd());
    `CHK(rx_frame_len, 8'h02)
    rdbuf(4);
    $display("test receive done");
    rxe(0, 8'h05);
    rdbuf(1);
    `CHK(ur != 0, 1'b1)
    rxe(2, 8'h00);
    $display("test underrun done");
    print_verdict();
  end
endmodule

`default_nettype wire
